// >>> core/graphics_pipeline_register_bank.sv
`timescale 1ns/1ps
`include "gp_bank_params.svh"

module graphics_pipeline_register_bank
  import gp_bank_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [15:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic engine_take_in,
  input wire logic pix_pattern_in,
  input wire logic pix_source_in,
  input wire logic pix_dest_in,
  output logic line_start_out,
  output logic copy_start_out,
  output logic [31:0] work_coords_out,
  output logic [31:0] work_extent_out,
  output logic [31:0] work_source_out,
  output logic [31:0] work_src_colors_out,
  output logic [63:0] work_fill_colors_out,
  output logic [127:0] work_fill_bits_out,
  output logic [31:0] work_raster_out,
  output logic [31:0] work_mode_out,
  output pattern_kind_t pattern_kind_out,
  output logic [31:0] legacy_write_path_ctl_out,
  output logic [31:0] legacy_read_path_ctl_out,
  output logic rop_bit_out
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic in_window;
  logic slot_hit;
  logic status_hit;
  logic [3:0] slot;

  always_comb begin
    in_window = (avs_address_in >= `GP_WIN_BASE) &&
                (avs_address_in < (`GP_WIN_BASE + `GP_WIN_SIZE));
    status_hit = (avs_address_in == `GP_OFS_COPY_STATE);
    slot_hit = 1'b1;
    slot = 4'h0;
    unique case (avs_address_in)
      `GP_OFS_DEST_COORD: slot = `GP_IDX_DEST_COORD;
      `GP_OFS_EXTENT: slot = `GP_IDX_EXTENT;
      `GP_OFS_SOURCE: slot = `GP_IDX_SOURCE;
      `GP_OFS_SRC_COLORS: slot = `GP_IDX_SRC_COLORS;
      `GP_OFS_FILL_COL_LO: slot = `GP_IDX_FILL_COL_LO;
      `GP_OFS_FILL_COL_HI: slot = `GP_IDX_FILL_COL_HI;
      `GP_OFS_FILL_BITS0: slot = `GP_IDX_FILL_BITS0;
      `GP_OFS_FILL_BITS1: slot = 4'(`GP_IDX_FILL_BITS0 + 4'h1);
      `GP_OFS_FILL_BITS2: slot = 4'(`GP_IDX_FILL_BITS0 + 4'h2);
      `GP_OFS_FILL_BITS3: slot = 4'(`GP_IDX_FILL_BITS0 + 4'h3);
      `GP_OFS_LEGACY_WR: slot = `GP_IDX_LEGACY_WR;
      `GP_OFS_LEGACY_RD: slot = `GP_IDX_LEGACY_RD;
      `GP_OFS_RASTER: slot = `GP_IDX_RASTER;
      `GP_OFS_LINE_LAUNCH: slot = `GP_IDX_LINE_LAUNCH;
      `GP_OFS_COPY_LAUNCH: slot = `GP_IDX_COPY_LAUNCH;
      default: slot_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  // Every access takes one wait cycle; the answer cycle is where
  // writes land, so read data can come straight from flops.
  bus_state_t bus_q;
  bus_state_t bus_d;
  logic req;
  logic wr_take;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  word_t regs_q [`GP_NUM_REGS];
  word_t regs_d [`GP_NUM_REGS];
  logic pending_q;
  logic pending_d;

  assign req = avs_read_in || avs_write_in;
  assign wr_take = (bus_q == BUS_ANSWER) && avs_write_in && in_window && slot_hit;
  assign avs_waitrequest_out = (bus_q != BUS_ANSWER);
  assign avs_readdata_out = rdata_q;

  always_comb begin
    bus_d = BUS_IDLE;
    rdata_d = rdata_q;
    unique case (bus_q)
      BUS_IDLE: begin
        if (req) begin
          bus_d = BUS_ANSWER;
          rdata_d = 32'h00000000;
          if (in_window && slot_hit) begin
            rdata_d = regs_q[slot];
          end else if (in_window && status_hit) begin
            rdata_d[`GP_STATE_PENDING_BIT] = pending_q;
          end
        end
      end
      BUS_ANSWER: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_q <= BUS_IDLE;
      rdata_q <= 32'h00000000;
    end else begin
      bus_q <= bus_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // Master registers
  // ------------------------------------------------------------
  logic line_launch;
  logic copy_launch;

  always_comb begin
    for (int i = 0; i < `GP_NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (wr_take) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable_in[b]) begin
          regs_d[slot][8*b +: 8] = avs_writedata_in[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < `GP_NUM_REGS; i++) begin
        regs_q[i] <= `GP_REG_RESET;
      end
    end else begin
      for (int i = 0; i < `GP_NUM_REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  assign line_launch = wr_take && (slot == `GP_IDX_LINE_LAUNCH);
  assign copy_launch = wr_take && (slot == `GP_IDX_COPY_LAUNCH);

  assign legacy_write_path_ctl_out = regs_q[`GP_IDX_LEGACY_WR];
  assign legacy_read_path_ctl_out = regs_q[`GP_IDX_LEGACY_RD];

  // ------------------------------------------------------------
  // Working copies
  // ------------------------------------------------------------
  // Snapshot taken on launch so software can stage the next job.
  logic [31:0] w_coords_q, w_coords_d;
  logic [31:0] w_extent_q, w_extent_d;
  logic [31:0] w_source_q, w_source_d;
  logic [31:0] w_srccol_q, w_srccol_d;
  logic [63:0] w_fillcol_q, w_fillcol_d;
  logic [127:0] w_bits_q, w_bits_d;
  logic [31:0] w_raster_q, w_raster_d;
  logic [31:0] w_mode_q, w_mode_d;
  logic line_start_q, line_start_d;
  logic copy_start_q, copy_start_d;
  logic rop_bit_q, rop_bit_d;
  pattern_kind_t pat_kind_q, pat_kind_d;

  always_comb begin
    w_coords_d = w_coords_q;
    w_extent_d = w_extent_q;
    w_source_d = w_source_q;
    w_srccol_d = w_srccol_q;
    w_fillcol_d = w_fillcol_q;
    w_bits_d = w_bits_q;
    w_raster_d = w_raster_q;
    w_mode_d = w_mode_q;
    if (line_launch || copy_launch) begin
      w_coords_d = regs_d[`GP_IDX_DEST_COORD];
      w_extent_d = regs_d[`GP_IDX_EXTENT];
      w_source_d = regs_d[`GP_IDX_SOURCE];
      w_srccol_d = regs_d[`GP_IDX_SRC_COLORS];
      w_fillcol_d = {regs_d[`GP_IDX_FILL_COL_HI], regs_d[`GP_IDX_FILL_COL_LO]};
      for (int k = 0; k < 4; k++) begin
        w_bits_d[32*k +: 32] = regs_d[4'(`GP_IDX_FILL_BITS0 + k)];
      end
      w_raster_d = regs_d[`GP_IDX_RASTER];
      w_mode_d = line_launch ? regs_d[`GP_IDX_LINE_LAUNCH] :
                               regs_d[`GP_IDX_COPY_LAUNCH];
    end
    line_start_d = line_launch;
    copy_start_d = copy_launch;
    unique case (w_raster_q[`GP_PAT_MODE_MSB:`GP_PAT_MODE_LSB])
      `GP_PAT_MODE_MONO: pat_kind_d = PAT_MONO;
      `GP_PAT_MODE_DITHER: pat_kind_d = PAT_DITHER;
      `GP_PAT_MODE_COLOR: pat_kind_d = PAT_COLOR;
      default: pat_kind_d = PAT_SOLID;
    endcase
    rop_bit_d = w_raster_q[{pix_pattern_in, pix_source_in, pix_dest_in}];
    pending_d = pending_q;
    if (engine_take_in) begin
      pending_d = 1'b0;
    end
    if (line_launch || copy_launch) begin
      pending_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      w_coords_q <= `GP_REG_RESET;
      w_extent_q <= `GP_REG_RESET;
      w_source_q <= `GP_REG_RESET;
      w_srccol_q <= `GP_REG_RESET;
      w_fillcol_q <= 64'h0000000000000000;
      w_bits_q <= '0;
      w_raster_q <= `GP_REG_RESET;
      w_mode_q <= `GP_REG_RESET;
      line_start_q <= 1'b0;
      copy_start_q <= 1'b0;
      rop_bit_q <= 1'b0;
      pat_kind_q <= PAT_SOLID;
      pending_q <= 1'b0;
    end else begin
      w_coords_q <= w_coords_d;
      w_extent_q <= w_extent_d;
      w_source_q <= w_source_d;
      w_srccol_q <= w_srccol_d;
      w_fillcol_q <= w_fillcol_d;
      w_bits_q <= w_bits_d;
      w_raster_q <= w_raster_d;
      w_mode_q <= w_mode_d;
      line_start_q <= line_start_d;
      copy_start_q <= copy_start_d;
      rop_bit_q <= rop_bit_d;
      pat_kind_q <= pat_kind_d;
      pending_q <= pending_d;
    end
  end

  assign work_coords_out = w_coords_q;
  assign work_extent_out = w_extent_q;
  assign work_source_out = w_source_q;
  assign work_src_colors_out = w_srccol_q;
  assign work_fill_colors_out = w_fillcol_q;
  assign work_fill_bits_out = w_bits_q;
  assign work_raster_out = w_raster_q;
  assign work_mode_out = w_mode_q;
  assign line_start_out = line_start_q;
  assign copy_start_out = copy_start_q;
  assign pattern_kind_out = pat_kind_q;
  assign rop_bit_out = rop_bit_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence line_write_s;
    bus_q == BUS_ANSWER && avs_write_in && avs_address_in == `GP_OFS_LINE_LAUNCH;
  endsequence

  sequence copy_write_s;
    bus_q == BUS_ANSWER && avs_write_in && avs_address_in == `GP_OFS_COPY_LAUNCH;
  endsequence

  answer_one_cycle_a: assert property (
    (bus_q == BUS_IDLE && req) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("answer not after one wait cycle");

  unmapped_read_zero_a: assert property (
    (bus_q == BUS_IDLE && avs_read_in && !in_window) |=> avs_readdata_out == 32'h00000000)
    else $error("unmapped read not zero");

  line_launch_pulse_a: assert property (
    line_write_s |=> line_start_out && !copy_start_out ##1 !line_start_out)
    else $error("line launch pulse wrong");

  copy_launch_pulse_a: assert property (
    copy_write_s |=> copy_start_out && !line_start_out ##1 !copy_start_out)
    else $error("copy launch pulse wrong");

  coords_snapshot_a: assert property (
    copy_write_s |=> work_coords_out == $past(regs_q[`GP_IDX_DEST_COORD])
                     && work_extent_out == $past(regs_q[`GP_IDX_EXTENT]))
    else $error("working copy not taken");

  fill_word_order_a: assert property (
    line_start_out |->
      work_fill_bits_out[127:96] == $past(regs_q[4'(`GP_IDX_FILL_BITS0 + 4'h3)])
      && work_fill_bits_out[31:0] == $past(regs_q[`GP_IDX_FILL_BITS0]))
    else $error("pattern word order wrong");

  rop_lookup_bit_a: assert property (
    ##1 rop_bit_out == $past(w_raster_q[{pix_pattern_in, pix_source_in, pix_dest_in}]))
    else $error("raster bit lookup wrong");

  pattern_kind_map_a: assert property (
    (w_raster_q[`GP_PAT_MODE_MSB:`GP_PAT_MODE_LSB] == `GP_PAT_MODE_MONO)
      |=> pattern_kind_out == PAT_MONO)
    else $error("mono pattern not selected");

  pending_set_wins_a: assert property (
    (line_launch || copy_launch) |=> pending_q [*2] or (pending_q ##1 $past(engine_take_in)))
    else $error("pending lost on launch");

  write_readback_a: assert property (
    (wr_take && avs_byteenable_in == 4'hf) |=> regs_q[$past(slot)] == $past(avs_writedata_in))
    else $error("full-word write not stored");

  pattern_dither_map_a: assert property (
    (w_raster_q[`GP_PAT_MODE_MSB:`GP_PAT_MODE_LSB] == `GP_PAT_MODE_DITHER)
      |=> pattern_kind_out == PAT_DITHER)
    else $error("dither pattern not selected");

  pattern_color_map_a: assert property (
    (w_raster_q[`GP_PAT_MODE_MSB:`GP_PAT_MODE_LSB] == `GP_PAT_MODE_COLOR)
      |=> pattern_kind_out == PAT_COLOR)
    else $error("colour pattern not selected");

  single_answer_a: assert property (
    (bus_q == BUS_ANSWER) |=> avs_waitrequest_out)
    else $error("answer held too long");

  status_pending_read_a: assert property (
    (bus_q == BUS_IDLE && avs_read_in && avs_address_in == `GP_OFS_COPY_STATE)
      |=> avs_readdata_out[`GP_STATE_PENDING_BIT] == $past(pending_q))
    else $error("pending bit not readable");

  fill_colors_snapshot_a: assert property (
    line_write_s |=> work_fill_colors_out ==
      {$past(regs_q[`GP_IDX_FILL_COL_HI]), $past(regs_q[`GP_IDX_FILL_COL_LO])})
    else $error("fill colours not taken");

  source_snapshot_a: assert property (
    line_write_s |=> work_source_out == $past(regs_q[`GP_IDX_SOURCE])
      && work_src_colors_out == $past(regs_q[`GP_IDX_SRC_COLORS]))
    else $error("source operands not taken");

  raster_mode_snapshot_a: assert property (
    copy_write_s |=> work_raster_out == $past(regs_q[`GP_IDX_RASTER])
      && work_mode_out == regs_q[`GP_IDX_COPY_LAUNCH])
    else $error("raster or mode not taken");

  working_hold_a: assert property (
    !(line_launch || copy_launch) |=> $stable(work_coords_out) && $stable(work_fill_bits_out))
    else $error("working copy changed without launch");

endmodule : graphics_pipeline_register_bank

// >>> core/gp_bank_params.svh
`ifndef GP_BANK_PARAMS_SVH
`define GP_BANK_PARAMS_SVH

// Register window, byte addresses above the graphics base
`define GP_WIN_BASE 16'h8100
`define GP_WIN_SIZE 16'h0200
`define GP_OFS_DEST_COORD 16'h8100
`define GP_OFS_EXTENT 16'h8104
`define GP_OFS_SOURCE 16'h8108
`define GP_OFS_SRC_COLORS 16'h810c
`define GP_OFS_FILL_COL_LO 16'h8110
`define GP_OFS_FILL_COL_HI 16'h8114
`define GP_OFS_FILL_BITS0 16'h8120
`define GP_OFS_FILL_BITS1 16'h8124
`define GP_OFS_FILL_BITS2 16'h8128
`define GP_OFS_FILL_BITS3 16'h812c
`define GP_OFS_LEGACY_WR 16'h8140
`define GP_OFS_LEGACY_RD 16'h8144
`define GP_OFS_RASTER 16'h8200
`define GP_OFS_LINE_LAUNCH 16'h8204
`define GP_OFS_COPY_LAUNCH 16'h8208
`define GP_OFS_COPY_STATE 16'h820c

// Storage slots
`define GP_IDX_DEST_COORD 4'h0
`define GP_IDX_EXTENT 4'h1
`define GP_IDX_SOURCE 4'h2
`define GP_IDX_SRC_COLORS 4'h3
`define GP_IDX_FILL_COL_LO 4'h4
`define GP_IDX_FILL_COL_HI 4'h5
`define GP_IDX_FILL_BITS0 4'h6
`define GP_IDX_LEGACY_WR 4'ha
`define GP_IDX_LEGACY_RD 4'hb
`define GP_IDX_RASTER 4'hc
`define GP_IDX_LINE_LAUNCH 4'hd
`define GP_IDX_COPY_LAUNCH 4'he
`define GP_NUM_REGS 15

// Fields and reset values
`define GP_ROP_MSB 7
`define GP_ROP_LSB 0
`define GP_PAT_MODE_MSB 9
`define GP_PAT_MODE_LSB 8
`define GP_PAT_MODE_MONO 2'h1
`define GP_PAT_MODE_DITHER 2'h2
`define GP_PAT_MODE_COLOR 2'h3
`define GP_STATE_PENDING_BIT 2
`define GP_REG_RESET 32'h00000000

`endif

// >>> core/gp_bank_pkg.sv
package gp_bank_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    PAT_SOLID,
    PAT_MONO,
    PAT_DITHER,
    PAT_COLOR
  } pattern_kind_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage : gp_bank_pkg

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
  import gp_bank_pkg::*;
  logic clk_in, sys_rst_in, avs_read_in, avs_write_in, engine_take_in;
  logic pix_pattern_in, pix_source_in, pix_dest_in, avs_waitrequest_out;
  logic [15:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd, seed, old;
  logic [3:0] avs_byteenable_in;
  logic line_start_out, copy_start_out, rop_bit_out;
  logic [31:0] work_coords_out, work_extent_out, work_source_out, work_src_colors_out;
  logic [63:0] work_fill_colors_out;
  logic [127:0] work_fill_bits_out;
  logic [31:0] work_raster_out, work_mode_out;
  logic [31:0] legacy_write_path_ctl_out, legacy_read_path_ctl_out;
  pattern_kind_t pattern_kind_out;
  int num_errors, n_checks, cycles;
  logic [31:0] model [15];
  logic [15:0] offs [15] = '{16'h8100, 16'h8104, 16'h8108, 16'h810c, 16'h8110, 16'h8114,
    16'h8120, 16'h8124, 16'h8128, 16'h812c, 16'h8140, 16'h8144, 16'h8200, 16'h8204, 16'h8208};

  graphics_pipeline_register_bank uut (.clk_in, .sys_rst_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .engine_take_in, .pix_pattern_in, .pix_source_in, .pix_dest_in,
    .line_start_out, .copy_start_out, .work_coords_out, .work_extent_out, .work_source_out,
    .work_src_colors_out, .work_fill_colors_out, .work_fill_bits_out, .work_raster_out,
    .work_mode_out, .pattern_kind_out, .legacy_write_path_ctl_out,
    .legacy_read_path_ctl_out, .rop_bit_out);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction : lfsr

  task automatic check(input string nm, input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  // Request is held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic wr_reg(input int i, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, offs[i], d, be);
    for (int b = 0; b < 4; b++) if (be[b]) model[i][8*b+:8] = d[8*b+:8];
  endtask : wr_reg

  task automatic rd_all();
    for (int i = 0; i < 15; i++) begin
      bus(1'b0, offs[i], 32'h00000000, 4'hf);
      check("readback", rd, model[i]);
    end
  endtask : rd_all

  // Launch index 13 draws a line, index 14 starts a copy
  task automatic launch(input int i);
    seed = lfsr(seed);
    wr_reg(i, seed, 4'hf);
    #1;
    check("line_start", line_start_out, i == 13);
    check("copy_start", copy_start_out, i == 14);
    check("work_coords", work_coords_out, model[0]);
    check("work_extent", work_extent_out, model[1]);
    check("work_source", work_source_out, model[2]);
    check("work_src_colors", work_src_colors_out, model[3]);
    check("work_fill_colors", work_fill_colors_out, {model[5], model[4]});
    check("work_fill_bits", work_fill_bits_out, {model[9], model[8], model[7], model[6]});
    check("work_raster", work_raster_out, model[12]);
    check("work_mode", work_mode_out, model[i]);
    @(posedge clk_in);
    #1;
    check("start_pulse_len", {line_start_out, copy_start_out}, 2'h0);
    check("pattern_kind", pattern_kind_out, model[12][9:8]);
  endtask : launch

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst_in = 1'b1;
    {avs_read_in, avs_write_in, engine_take_in} = 3'h0;
    {pix_pattern_in, pix_source_in, pix_dest_in} = 3'h0;
    avs_address_in = 16'h0000;
    avs_writedata_in = 32'h00000000;
    avs_byteenable_in = 4'h0;
    seed = 32'h00000062;
    for (int i = 0; i < 15; i++) model[i] = 32'h00000000;
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    check("waitrequest_idle", avs_waitrequest_out, 1'b1);
    rd_all();
    check("legacy_wr_reset", legacy_write_path_ctl_out, 32'h00000000);
    $display("test reset_values done");

    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 13; i++) begin
        seed = lfsr(seed);
        wr_reg(i, seed, (r == 2) ? seed[3:0] : 4'hf);
      end
    end
    rd_all();
    check("legacy_wr_out", legacy_write_path_ctl_out, model[10]);
    check("legacy_rd_out", legacy_read_path_ctl_out, model[11]);
    $display("test random_access done");

    // Holes inside and addresses outside the window read zero and hold nothing
    foreach (offs[k]) if (k < 4) begin
      bus(1'b1, (k == 0) ? 16'h8118 : (k == 1) ? 16'h81fc : (k == 2) ? 16'h8300 : 16'h80fc,
          32'hffffffff, 4'hf);
      bus(1'b0, avs_address_in, 32'h00000000, 4'hf);
      check("unmapped_read", rd, 32'h00000000);
    end
    rd_all();
    $display("test unmapped done");

    launch(13);
    old = model[0];
    wr_reg(0, ~old, 4'hf);
    check("work_hold", work_coords_out, old);
    launch(14);
    bus(1'b0, 16'h820c, 32'h00000000, 4'hf);
    check("pending_set", rd[2], 1'b1);
    @(posedge clk_in);
    engine_take_in <= 1'b1;
    @(posedge clk_in);
    engine_take_in <= 1'b0;
    bus(1'b0, 16'h820c, 32'h00000000, 4'hf);
    check("pending_clear", rd[2], 1'b0);
    // Clear and launch land on one edge: the launch must win
    engine_take_in <= 1'b1;
    seed = lfsr(seed);
    wr_reg(14, seed, 4'hf);
    engine_take_in <= 1'b0;
    bus(1'b0, 16'h820c, 32'h00000000, 4'hf);
    check("pending_set_wins", rd[2], 1'b1);
    $display("test launch done");

    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wr_reg(12, {seed[31:10], k[1:0], seed[7:0]}, 4'hf);
      launch(14 - (k % 2));
      for (int p = 0; p < 8; p++) begin
        @(posedge clk_in);
        {pix_pattern_in, pix_source_in, pix_dest_in} <= p[2:0];
        @(posedge clk_in);
        #1;
        check("rop_bit", rop_bit_out, model[12][p]);
      end
    end
    $display("test raster done");

    // Reset in mid-run must wipe written registers and working copies
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 15; i++) model[i] = 32'h00000000;
    rd_all();
    check("work_raster_reset", work_raster_out, 32'h00000000);
    check("legacy_wr_mid_reset", legacy_write_path_ctl_out, 32'h00000000);
    $display("test mid_reset done");
    finish_test();
  end
endmodule : tb
